// ==== rtl/mod_counter.sv ====
/*
 Free running modulo counter with a terminal count pulse.
 Assumes a synchronous reset and a clock enable from the parent.
*/
`timescale 1ns/1ns
`default_nettype none
module mod_counter #(
   parameter int W = 4
) (
   // Clock and control
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic         step_i,
   input  wire logic [W-1:0] last_i,
   // Terminal count
   output logic              tc_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } cnt_state_t;
   cnt_state_t s, next_s;

   // Count to last, then wrap
   always_comb begin
      next_s = s;
      if (step_i) begin
         if (s.cnt >= last_i) next_s.cnt = '0;
         else next_s.cnt = s.cnt + W'(1);
      end
   end
   assign tc_o = step_i && (s.cnt >= last_i);

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) s <= '0;
      else if (ce_i) s <= next_s;
   end
endmodule // mod_counter
`default_nettype wire

// ==== rtl/phase_comparator.sv ====
/*
 Sequential phase frequency comparator with active low pump outputs.
 Assumes both edge inputs are one-cycle pulses in the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module phase_comparator (
   // Clock and control
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // Edges
   input  wire logic ref_edge_i,
   input  wire logic fb_edge_i,
   // Pump outputs, active low
   output logic      pump_up_pulse_n_o,
   output logic      pump_down_pulse_n_o
);
   typedef struct packed {
      logic up;
      logic dn;
   } pfd_state_t;
   pfd_state_t s, next_s;

   // Set on own edge, both clear once both are seen
   always_comb begin
      next_s = s;
      if (ref_edge_i) next_s.up = 1'b1;
      if (fb_edge_i) next_s.dn = 1'b1;
      if (next_s.up && next_s.dn) begin
         next_s.up = 1'b0;
         next_s.dn = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) s <= '0;
      else if (ce_i) s <= next_s;
   end
   // Width equals phase error; both high when aligned
   assign pump_up_pulse_n_o   = ~s.up;
   assign pump_down_pulse_n_o = ~s.dn;
endmodule // phase_comparator
`default_nettype wire

// ==== rtl/synth_loop_divider_control.sv ====
/*
 Digital part of a single loop synthesizer: reference divider, dual
 modulus feedback divider, serial tuning load, comparator, low band
 switch, lock detector, load check, and a Wishbone register file.
 Assumes the serial clock, data and enable pins are synchronous to clk_i
 and that reference and prescaled feedback arrive as sampled levels.
*/
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module synth_loop_divider_control
   import synth_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             irq_o,
   // Serial tuning link
   input  wire logic        ser_clk_i,
   input  wire logic        ser_data_i,
   input  wire logic        ser_enable_i,
   // Reference and feedback
   input  wire logic        reference_input_i,
   input  wire logic        prescaler_out_i,
   output logic             modulus_high_o,
   // Loop outputs
   output logic             pump_up_pulse_n_o,
   output logic             pump_down_pulse_n_o,
   output logic             low_band_switch_out_o,
   output logic             lock_detector_o,
   output logic             load_check_output_o,
   output logic [9:0]       division_factor_o
);
   // ===========================================================
   // State
   typedef struct packed {
      logic              sclk_d;
      logic              en_d;
      logic              ref_d;
      logic              pre_d;
      logic [WORD_W-1:0] shift;
      logic [N_W-1:0]    n_val;
      logic [N_W-1:0]    digits;
      logic [3:0]        high_left;   // Prescaler cycles still at /11
      logic [6:0]        low_left;    // Prescaler cycles still at /10
      logic              mod_high;
      logic              check;
      logic              unlocked;
      logic [3:0]        agree;
      logic              selftest;
      logic [1:0]        irq_stat;
      logic [1:0]        irq_mask;
      logic              ack;
      logic [31:0]       rdata;
   } top_state_t;
   top_state_t s, next_s;

   logic       ref_step;
   logic       ref_edge;
   logic       pre_edge;
   logic       fb_edge;
   logic [3:0] d_hund;
   logic [3:0] d_ten;
   logic [3:0] d_one;
   logic [N_W-1:0] dec_val;
   logic       dec_ok;
   logic [N_W-1:0] n_hund;
   logic [N_W-1:0] n_units;
   logic       wb_req;
   logic       enable_fall;

   // ===========================================================
   // Edge detection on sampled pins
   assign ref_step    = reference_input_i && !s.ref_d;
   assign pre_edge    = prescaler_out_i && !s.pre_d;
   assign enable_fall = s.en_d && !ser_enable_i;
   assign wb_req      = cyc_i && stb_i && !s.ack;

   // Reference divide by eight
   mod_counter #(
      .W(3)
   ) ref_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .step_i (ref_step),
      .last_i (REF_DIV_LAST),
      .tc_o   (ref_edge)
   );

   // Serial word as three BCD digits
   assign d_hund  = s.shift[11:8];
   assign d_ten   = s.shift[7:4];
   assign d_one   = s.shift[3:0];
   assign dec_val = N_W'(d_hund) * N_W'(100) + N_W'(d_ten) * N_W'(10) + N_W'(d_one);
   assign dec_ok  = (d_hund <= 4'h2) && (d_ten <= 4'h9) && (d_one <= 4'h9)
                    && (dec_val <= DIGIT_MAX);

   // Split N into prescaler cycles: N = 10*P + A, A cycles at /11
   assign n_units = s.n_val % N_W'(10);
   assign n_hund  = s.n_val / N_W'(10);

   // Feedback edge: end of a full divide by N cycle
   assign fb_edge = pre_edge && (s.low_left == 7'h0) && !s.mod_high
                    && (s.high_left == 4'h0);

   // ===========================================================
   // Next state
   always_comb begin
      next_s          = s;
      next_s.sclk_d   = ser_clk_i;
      next_s.en_d     = ser_enable_i;
      next_s.ref_d    = reference_input_i;
      next_s.pre_d    = prescaler_out_i;
      next_s.check    = 1'b0;
      next_s.ack      = 1'b0;
      // Shift on serial clock rise inside the enable window
      if (ser_enable_i && ser_clk_i && !s.sclk_d) begin
         next_s.shift = {s.shift[WORD_W-2:0], ser_data_i};
      end
      // Take the word only when the enable pulse ends
      if (enable_fall && dec_ok) begin
         next_s.digits = dec_val;
         next_s.n_val  = N_BASE + dec_val;
         next_s.check  = 1'b1;
      end
      // Modulus sequencing, reload at terminal count
      if (pre_edge) begin
         if (s.high_left != 4'h0) begin
            next_s.high_left = s.high_left - 4'h1;
            next_s.mod_high  = (s.high_left != 4'h1);
         end else if (s.low_left != 7'h0) begin
            next_s.low_left  = s.low_left - 7'h1;
            next_s.mod_high  = 1'b0;
         end else begin
            next_s.high_left = n_units[3:0];
            next_s.low_left  = 7'(n_hund - n_units - N_W'(1));
            next_s.mod_high  = (n_units != N_W'(0));
         end
      end
      // Lock: edges arrive together repeatedly
      if (ref_edge && fb_edge) begin
         if (s.agree != LOCK_COUNT) next_s.agree = s.agree + 4'h1;
         else next_s.unlocked = 1'b0;
      end else if (ref_edge || fb_edge) begin
         next_s.agree    = 4'h0;
         next_s.unlocked = 1'b1;
      end
      // Wishbone access
      if (wb_req) begin
         next_s.ack = 1'b1;
         unique case (adr_i)
            ADDR_CTRL:   next_s.rdata = {31'h0, s.selftest};
            ADDR_STATUS: next_s.rdata = {9'h0, s.n_val, 2'h0, s.digits,
                                         s.unlocked};
            ADDR_IRQ:    next_s.rdata = {30'h0, s.irq_stat};
            ADDR_MASK:   next_s.rdata = {30'h0, s.irq_mask};
            default:     next_s.rdata = 32'h0;
         endcase
         if (we_i && sel_i[0]) begin
            if (adr_i == ADDR_CTRL) next_s.selftest = dat_i[CTRL_SELFTEST];
            if (adr_i == ADDR_MASK) next_s.irq_mask = dat_i[1:0];
         end
         if (!we_i && adr_i == ADDR_IRQ) next_s.irq_stat = 2'h0;
      end
      // Events set sticky bits, winning over a read clear
      if (s.check) next_s.irq_stat[IRQ_LOAD] = 1'b1;
      if (!s.unlocked && next_s.unlocked) next_s.irq_stat[IRQ_UNLOCK] = 1'b1;
   end

   // ===========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s          <= '0;
         s.n_val    <= N_BASE;
         s.unlocked <= 1'b1;
         s.irq_mask <= MASK_RST;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   // Comparator
   phase_comparator pfd (
      .clk_i               (clk_i),
      .rst_i               (rst_i),
      .ce_i                (ce_i),
      .ref_edge_i          (ref_edge),
      .fb_edge_i           (fb_edge),
      .pump_up_pulse_n_o   (pump_up_pulse_n_o),
      .pump_down_pulse_n_o (pump_down_pulse_n_o)
   );

   // Outputs
   assign modulus_high_o        = s.mod_high;
   assign low_band_switch_out_o = (s.digits < LOW_BAND_LIM);
   assign lock_detector_o       = s.unlocked;
   assign load_check_output_o   = s.check;
   assign division_factor_o     = s.n_val;
   assign dat_o                 = s.rdata;
   assign ack_o                 = s.ack && cyc_i && stb_i;
   assign irq_o                 = |(s.irq_stat & s.irq_mask);
endmodule // synth_loop_divider_control
`default_nettype wire

// ==== rtl/synth_pkg.sv ====
/*
 Package for the loop divider and comparator block: serial word layout,
 division limits, divider ratios, register offsets and fields.
 Assumes a single 25 MHz clock domain and a classic Wishbone slave.
*/
package synth_pkg;
   // ===========================================================
   // Division factor
   localparam int          N_W          = 10;
   localparam logic [9:0]  N_BASE       = 10'h1b9;   // 441
   localparam logic [9:0]  N_MAX        = 10'h2e4;   // 740
   localparam logic [9:0]  DIGIT_MAX    = 10'h12b;   // 299
   localparam logic [9:0]  LOW_BAND_LIM = 10'h014;   // 2.0 MHz in 100 kHz steps
   localparam int          WORD_W       = 12;        // Three BCD digits, MSB first
   // ===========================================================
   // Reference and prescaler
   localparam logic [2:0]  REF_DIV_LAST = 3'h7;      // Divide by 8
   localparam logic [3:0]  PRE_LOW_LAST = 4'h9;      // Divide by 10
   localparam logic [3:0]  PRE_HIGH_LAST = 4'ha;     // Divide by 11
   // ===========================================================
   // Register offsets (byte addresses)
   localparam logic [3:0]  ADDR_CTRL    = 4'h0;
   localparam logic [3:0]  ADDR_STATUS  = 4'h4;
   localparam logic [3:0]  ADDR_IRQ     = 4'h8;
   localparam logic [3:0]  ADDR_MASK    = 4'hc;
   // Control fields
   localparam int          CTRL_SELFTEST = 0;
   localparam logic [1:0]  MASK_RST     = 2'h0;
   // Interrupt fields
   localparam int          IRQ_LOAD     = 0;
   localparam int          IRQ_UNLOCK   = 1;
   // Lock detector: agreeing cycles counted; lock comes on the next agreeing cycle after this count
   localparam logic [3:0]  LOCK_COUNT   = 4'h8;
endpackage

// ==== test/host_tuning_model.sv ====
/* Host tuning controller model: shifts tuning words, watches lock.
   Tasks are called by the bench at a clock edge. */
`timescale 1ns/1ns
`default_nettype none
module host_tuning_model #(
   parameter int HALF = 16
) (
   // Clock and status
   input  wire logic  clk_i,
   input  wire logic  self_test_i,
   input  wire logic  lock_i,
   input  wire logic  check_i,
   // Serial link and readback
   output logic       sck_o,
   output logic       sdo_o,
   output logic       sen_o,
   output logic       fault_o,
   output logic [7:0] check_cnt_o
);
   logic bit_q, idle;
   // Released data line toggles every cycle
   assign sdo_o = sen_o ? bit_q : idle;
   initial begin
      {sck_o, sen_o, bit_q, idle, check_cnt_o} = '0;
   end
   // Lock watch and check readback
   always @(posedge clk_i) begin
      idle <= ~idle;
      fault_o <= lock_i;
      if (check_i) check_cnt_o <= check_cnt_o + 8'h01;
   end
   // Open enable, shift MSB first, data moves on falling serial clock
   task automatic open_shift(input logic [11:0] w);
      if (self_test_i) begin
         sen_o <= 1'b1;
         for (int i = 11; i >= 0; i--) begin
            bit_q <= w[i];
            repeat (HALF) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            sck_o <= 1'b0;
         end
      end
   endtask
   task automatic close_enable;
      repeat (HALF) @(posedge clk_i);
      sen_o <= 1'b0;
   endtask
endmodule // host_tuning_model
`default_nettype wire

// ==== test/synth_assertions.sv ====
/* Port checker for the loop divider block.
   Bound to the top module; one clock, synchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module synth_assertions
   import synth_pkg::*;
(
   // Watched ports
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       irq_o,
   input wire logic       ser_enable_i,
   input wire logic       pump_up_pulse_n_o,
   input wire logic       pump_down_pulse_n_o,
   input wire logic       low_band_switch_out_o,
   input wire logic       lock_detector_o,
   input wire logic       load_check_output_o,
   input wire logic [9:0] division_factor_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus request and factor change, ignoring the reset load
   sequence wb_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence n_moved;
      !$past(rst_i) && $changed(division_factor_o);
   endsequence
   // Assertions
   a_ack_answer: assert property (wb_req |=> ack_o) // [WB]
      else $error("ack late");
   a_ack_single: assert property (ack_o |=> !ack_o) // [WB]
      else $error("ack held");
   a_n_range: assert property (division_factor_o >= N_BASE && division_factor_o <= N_MAX)
      else $error("factor out of range");
   a_check_pulse: assert property (load_check_output_o |=> !load_check_output_o)
      else $error("check pulse too long");
   a_n_at_close: assert property (n_moved |-> !ser_enable_i)
      else $error("factor changed while enabled");
   a_n_checked: assert property (n_moved |-> ((##[0:1] load_check_output_o) or $past(load_check_output_o)))
      else $error("factor changed without check pulse");
   a_low_band: assert property ($stable(division_factor_o) && division_factor_o == $past(division_factor_o, 2)
      |-> low_band_switch_out_o == (division_factor_o < 10'h1cd))
      else $error("low band wrong");
   a_reset_state: assert property ($fell(rst_i) |-> lock_detector_o && pump_up_pulse_n_o
      && pump_down_pulse_n_o && !irq_o && division_factor_o == N_BASE)
      else $error("reset state wrong");
endmodule // synth_assertions
bind synth_loop_divider_control synth_assertions chk_u (.*);
`default_nettype wire

// ==== test/synth_loop_divider_control_test.sv ====
/* Bench for the loop divider: registers, serial loads, divider ratio
   and pump direction. Assumes the host model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module synth_loop_divider_control_test
   import synth_pkg::*;
;
   logic        clk, rst, ce, cyc, stb, we, ack, irq, sck, sdo, sen, ref_in, pre;
   logic        mhi, pu, pd, lb, lock, lchk, st;
   logic [3:0]  adr;
   logic [31:0] dw, dr, rd;
   logic [9:0]  nf, n_exp;
   logic [7:0]  cc;
   int          num_errors, comparisons, ref_half, ref_cnt, ups, dns;
   logic [11:0] words [7] = '{12'h157, 12'h019, 12'h020, 12'h299, 12'h300, 12'h1a5, 12'h000};
   synth_loop_divider_control dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dw), .dat_o(dr), .ack_o(ack),
      .irq_o(irq), .ser_clk_i(sck), .ser_data_i(sdo), .ser_enable_i(sen),
      .reference_input_i(ref_in), .prescaler_out_i(pre), .modulus_high_o(mhi),
      .pump_up_pulse_n_o(pu), .pump_down_pulse_n_o(pd), .low_band_switch_out_o(lb),
      .lock_detector_o(lock), .load_check_output_o(lchk), .division_factor_o(nf));
   host_tuning_model host_u (.clk_i(clk), .self_test_i(st), .lock_i(lock), .check_i(lchk),
      .sck_o(sck), .sdo_o(sdo), .sen_o(sen), .fault_o(), .check_cnt_o(cc));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Prescaler rises every second cycle, reference every 2*ref_half
   always @(posedge clk) begin
      pre <= ~pre;
      ref_cnt = ref_cnt + 1;
      if (ref_cnt >= ref_half) begin
         ref_cnt = 0;
         ref_in <= ~ref_in;
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s: %h vs %h", $time, m, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dw <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dr;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      wb(1'b0, ADDR_MASK, 32'h0, rd);
      check(rd, 32'h0, "mask reset"); // [IRQ]
      wb(1'b1, ADDR_STATUS, 32'hffffffff, rd);
      wb(1'b0, ADDR_STATUS, 32'h0, rd);
      check(32'(rd[0]), 32'h1, "unlocked");
      check(32'(rd[22:13]), 32'(N_BASE), "status");
      wb(1'b0, 4'h2, 32'h0, rd);
      check(rd, 32'h0, "unmapped"); // [WB]
      wb(1'b1, ADDR_MASK, 32'h1, rd);
      wb(1'b1, ADDR_CTRL, 32'h1, rd);
      wb(1'b0, ADDR_CTRL, 32'h0, rd);
      check(rd, 32'h1, "ctrl");
      st <= 1'b1;
      @(posedge clk);
   endtask
   task automatic t_load(input logic [11:0] w);
      logic       ok;
      logic [7:0] c0;
      logic [9:0] n0;
      c0 = cc;
      n0 = n_exp;
      ok = w[11:8] <= 4'h2 && w[7:4] <= 4'h9 && w[3:0] <= 4'h9;
      n_exp = ok ? N_BASE + 10'(w[11:8]) * 10'h064 + 10'(w[7:4]) * 10'h00a + 10'(w[3:0]) : n0;
      host_u.open_shift(w);
      check(32'(nf), 32'(n0), "early n");
      host_u.close_enable;
      repeat (6) @(posedge clk);
      check(32'(nf), 32'(n_exp), "n");
      check(32'(cc - c0), 32'(ok), "pulse");
      check(32'(lb), 32'(n_exp < N_BASE + 10'h014), "band");
      check(32'(irq), 32'(ok), "irq"); // [IRQ]
      wb(1'b0, ADDR_IRQ, 32'h0, rd);
      check(32'(rd[IRQ_LOAD]), 32'(ok), "irq bit"); // [IRQ]
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0, "irq clear"); // [IRQ]
   endtask
   // Cycles at high modulus over one whole loop of N/10 prescaler periods
   task automatic t_mod;
      int hi;
      int loop_cycles;
      hi = 0;
      loop_cycles = 2 * (int'(n_exp) / 10);
      repeat (4 * n_exp) @(posedge clk);
      repeat (loop_cycles) begin
         @(negedge clk);
         if (mhi === 1'b1) hi++;
      end
      check(32'(hi), 32'(2 * (int'(n_exp) % 10)), "modulus");
   endtask
   task automatic run_ref(input int half);
      ref_half = half;
      repeat (5000) @(posedge clk);
      ups = 0;
      dns = 0;
      repeat (8000) begin
         @(posedge clk);
         if (pu === 1'b0) ups++;
         if (pd === 1'b0) dns++;
      end
   endtask
   task automatic t_pumps;
      int wide;
      run_ref(2);
      wide = ups;
      check(32'(ups > 0), 32'h1, "up");
      check(32'(dns), 32'h0, "no down");
      check(32'(lock), 32'h1, "lock");
      run_ref(4);
      check(32'(ups < wide), 32'h1, "narrow");
      run_ref(250);
      check(32'(dns > 0), 32'h1, "down");
      check(32'(ups), 32'h0, "no up");
   endtask
   initial begin
      {rst, ce} = 2'b11;
      {cyc, stb, we, adr, dw, ref_in, pre, st} = '0;
      num_errors = 0;
      comparisons = 0;
      ref_cnt = 0;
      ref_half = 16;
      n_exp = N_BASE;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs;
      foreach (words[i]) begin
         t_load(words[i]);
         t_mod;
      end
      t_pumps;
      print_verdict;
   end
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      print_verdict;
   end
endmodule // synth_loop_divider_control_test
`default_nettype wire
